// ===== tsc_client.sv
/*
 * Two-wire serial client port of a temperature sensor, with alert pin.
 * Assumes bus pins already synchronous to clk_sys, a register file outside
 * that returns the word addressed by reg_ptr and drains written words.
 */
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Data edges while clock high mark start/stop
// - Answer only address 0011 plus straps
// - Eighth address bit chooses read or write
// - Acknowledge each accepted received byte
// - One register per access, no advance
// - Pointer kept; bare reads use it
// - Start or stop mid-byte releases data line
// - Host not-acknowledge ends read, line released
// - Data line changes only while clock low
// - Stuck clock beyond timeout resets interface
// - Timeout lies between 25 and 35 ms
// - Acknowledge held low across ninth clock
// - Client only, never drives clock or conditions
// - No clock stretching, bit ready in low phase
// - Bit timing derived from host clock edges; timeout counts system clock cycles
// - Idle bus means both lines high
// - Alert pulled active when temperature out of limits
// - Pointers above 1001 are not acknowledged
module tsc_client #(
    parameter int TOUT_CYCLES = tsc_pkg::TOUT_CYC
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    input wire logic addr_strap_bit0,
    input wire logic addr_strap_bit1,
    input wire logic addr_strap_bit2,
    input wire logic temp_out_of_limit,
    output logic alert_out,
    output logic alert_oe_n,
    output logic [3:0] reg_ptr,
    input wire logic [15:0] rd_word,
    output logic wr_valid,
    output logic [19:0] wr_data,
    input wire logic wr_ready
);
    // Previous samples of the bus lines
    logic scl_q_reg, sda_q_reg;
    // Bus events, combinational from the samples
    logic start_det, stop_det, scl_rise, scl_fall;
    // Byte-level state
    tsc_pkg::tsc_state_type state_reg, state_next;
    logic [3:0] bit_reg, bit_next; // Rising edges seen in byte
    logic [1:0] byte_reg, byte_next; // Byte position in access
    logic [7:0] shift_reg, shift_next; // Received or sent byte
    logic [7:0] msb_reg, msb_next; // Held high data byte
    logic [7:0] lsb_reg, lsb_next; // Low byte of read word
    logic rd_reg, rd_next; // Access is a read
    logic hack_reg, hack_next; // Host acknowledged last byte
    logic [3:0] ptr_reg, ptr_next; // Register pointer
    logic oe_n_reg, oe_n_next; // Low pulls data line down
    // Timeout counter
    logic [tsc_pkg::TOUT_W-1:0] tcnt_reg, tcnt_next;
    logic tout_hit;
    // Alert pin drive
    logic alert_oe_n_reg, alert_oe_n_next;
    // Decisions at the end of a received byte
    logic addr_match, ptr_ok, ack_now, byte_end;
    // Write buffer handshake
    logic push, fifo_ready;

    // Edge and condition detection
    always_comb begin
        scl_rise = scl_in && !scl_q_reg;
        scl_fall = !scl_in && scl_q_reg;
        start_det = scl_in && scl_q_reg && sda_q_reg && !sda_in;
        stop_det = scl_in && scl_q_reg && !sda_q_reg && sda_in;
    end

    // Sample history; idle bus reads as both lines high
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            scl_q_reg <= 1'b1;
            sda_q_reg <= 1'b1;
        end else begin
            scl_q_reg <= scl_in;
            sda_q_reg <= sda_in;
        end
    end

    // Timeout: counts cycles without a clock edge while busy
    always_comb begin
        tout_hit = (tcnt_reg == tsc_pkg::TOUT_W'(TOUT_CYCLES - 1));
        if (state_reg == tsc_pkg::ST_IDLE || scl_rise || scl_fall) begin
            tcnt_next = '0;
        end else if (tout_hit) begin
            tcnt_next = '0;
        end else begin
            tcnt_next = tcnt_reg + tsc_pkg::TOUT_W'(1);
        end
    end

    // Counter register
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            tcnt_reg <= '0;
        end else begin
            tcnt_reg <= tcnt_next;
        end
    end

    // Acknowledge decision for the byte just received
    always_comb begin
        byte_end = (state_reg == tsc_pkg::ST_RX) && scl_fall && (bit_reg == tsc_pkg::BIT_LAST);
        addr_match = (shift_reg[7:1] == {tsc_pkg::ADDR_HI, addr_strap_bit2,
                                         addr_strap_bit1, addr_strap_bit0});
        ptr_ok = (shift_reg <= tsc_pkg::PTR_MAX);
        unique case (byte_reg)
            tsc_pkg::BI_ADDR: ack_now = addr_match;
            tsc_pkg::BI_PTR: ack_now = ptr_ok;
            tsc_pkg::BI_MSB: ack_now = 1'b1;
            tsc_pkg::BI_LSB: ack_now = fifo_ready;
        endcase
        // Full buffer cannot stall the clock, so the byte is refused
        push = byte_end && (byte_reg == tsc_pkg::BI_LSB) && fifo_ready;
    end

    // Byte-level next state
    always_comb begin
        state_next = state_reg;
        bit_next = bit_reg;
        byte_next = byte_reg;
        shift_next = shift_reg;
        msb_next = msb_reg;
        lsb_next = lsb_reg;
        rd_next = rd_reg;
        hack_next = hack_reg;
        ptr_next = ptr_reg;
        oe_n_next = oe_n_reg;
        if (tout_hit || stop_det) begin
            // Abandon everything, keep the pointer
            state_next = tsc_pkg::ST_IDLE;
            oe_n_next = 1'b1;
        end else if (start_det) begin
            // Start or repeated start; any byte in flight is dropped
            state_next = tsc_pkg::ST_RX;
            bit_next = tsc_pkg::BIT_ZERO;
            byte_next = tsc_pkg::BI_ADDR;
            oe_n_next = 1'b1;
        end else begin
            unique case (state_reg)
                tsc_pkg::ST_IDLE, tsc_pkg::ST_WAIT: begin
                    // Released, waiting for the host's next condition
                    oe_n_next = 1'b1;
                end
                tsc_pkg::ST_RX: begin
                    if (scl_rise) begin
                        // Sample while clock is high
                        shift_next = {shift_reg[6:0], sda_in};
                        bit_next = bit_reg + 4'h1;
                    end else if (byte_end) begin
                        // Present acknowledge during the low phase
                        state_next = tsc_pkg::ST_RX_ACK;
                        oe_n_next = !ack_now;
                        if (byte_reg == tsc_pkg::BI_ADDR) begin
                            rd_next = shift_reg[0];
                        end
                        if (byte_reg == tsc_pkg::BI_PTR && ptr_ok) begin
                            ptr_next = shift_reg[3:0];
                        end
                        if (byte_reg == tsc_pkg::BI_MSB) begin
                            msb_next = shift_reg;
                        end
                    end
                end
                tsc_pkg::ST_RX_ACK: begin
                    if (scl_fall) begin
                        // Hold ack until the ninth clock has fallen
                        oe_n_next = 1'b1;
                        bit_next = tsc_pkg::BIT_ZERO;
                        if (oe_n_reg) begin
                            state_next = tsc_pkg::ST_WAIT;
                        end else if (byte_reg == tsc_pkg::BI_ADDR && rd_reg) begin
                            // Read: word of the kept pointer, high byte first
                            state_next = tsc_pkg::ST_TX;
                            shift_next = rd_word[15:8];
                            lsb_next = rd_word[7:0];
                            oe_n_next = rd_word[15];
                            byte_next = tsc_pkg::BI_MSB;
                        end else if (byte_reg == tsc_pkg::BI_LSB) begin
                            // One register only; later bytes are refused
                            state_next = tsc_pkg::ST_WAIT;
                        end else begin
                            state_next = tsc_pkg::ST_RX;
                            byte_next = byte_reg + 2'h1;
                        end
                    end
                end
                tsc_pkg::ST_TX: begin
                    if (scl_rise) begin
                        bit_next = bit_reg + 4'h1;
                    end else if (scl_fall) begin
                        if (bit_reg == tsc_pkg::BIT_LAST) begin
                            // Release for the host's acknowledge
                            state_next = tsc_pkg::ST_TX_ACK;
                            oe_n_next = 1'b1;
                        end else begin
                            // Next bit goes out right after the fall
                            shift_next = {shift_reg[6:0], 1'b0};
                            oe_n_next = shift_reg[6];
                        end
                    end
                end
                tsc_pkg::ST_TX_ACK: begin
                    if (scl_rise) begin
                        hack_next = !sda_in;
                    end else if (scl_fall) begin
                        bit_next = tsc_pkg::BIT_ZERO;
                        if (hack_reg && byte_reg == tsc_pkg::BI_MSB) begin
                            state_next = tsc_pkg::ST_TX;
                            shift_next = lsb_reg;
                            oe_n_next = lsb_reg[7];
                            byte_next = tsc_pkg::BI_LSB;
                        end else begin
                            // End of read: stay released for the stop
                            state_next = tsc_pkg::ST_WAIT;
                        end
                    end
                end
                default: begin
                    state_next = tsc_pkg::ST_IDLE;
                    oe_n_next = 1'b1;
                end
            endcase
        end
    end

    // Byte-level registers
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state_reg <= tsc_pkg::ST_IDLE;
            bit_reg <= tsc_pkg::BIT_ZERO;
            byte_reg <= tsc_pkg::BI_ADDR;
            shift_reg <= 8'h00;
            msb_reg <= 8'h00;
            lsb_reg <= 8'h00;
            rd_reg <= 1'b0;
            hack_reg <= 1'b0;
            ptr_reg <= tsc_pkg::PTR_RST;
            oe_n_reg <= 1'b1;
        end else begin
            state_reg <= state_next;
            bit_reg <= bit_next;
            byte_reg <= byte_next;
            shift_reg <= shift_next;
            msb_reg <= msb_next;
            lsb_reg <= lsb_next;
            rd_reg <= rd_next;
            hack_reg <= hack_next;
            ptr_reg <= ptr_next;
            oe_n_reg <= oe_n_next;
        end
    end

    // Alert pin: open drain, pulled low while out of limits
    always_comb begin
        alert_oe_n_next = !temp_out_of_limit;
    end

    // Alert register
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            alert_oe_n_reg <= 1'b1;
        end else begin
            alert_oe_n_reg <= alert_oe_n_next;
        end
    end

    // Written words wait here until the register file takes them
    tsc_fifo #(
        .WIDTH(tsc_pkg::FIFO_W),
        .DEPTH(tsc_pkg::FIFO_D)
    ) u_wr_fifo (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .in_valid(push),
        .in_data({ptr_reg, msb_reg, shift_reg}),
        .in_ready(fifo_ready),
        .out_ready(wr_ready),
        .out_valid(wr_valid),
        .out_data(wr_data)
    );

    // Open-drain pins only ever pull low
    assign sda_out = 1'b0;
    assign sda_oe_n = oe_n_reg;
    assign alert_out = 1'b0;
    assign alert_oe_n = alert_oe_n_reg;
    assign reg_ptr = ptr_reg;

    // Checks on the block's own behaviour
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    property p_start_release;
        start_det && !stop_det && !tout_hit |=> state_reg == tsc_pkg::ST_RX && oe_n_reg;
    endproperty
    a_start_release: assert property (p_start_release) else $error("start not honoured");

    property p_stop_idle;
        stop_det |=> state_reg == tsc_pkg::ST_IDLE && oe_n_reg && $stable(ptr_reg);
    endproperty
    a_stop_idle: assert property (p_stop_idle) else $error("stop not honoured");

    property p_addr_ack;
        byte_end && byte_reg == tsc_pkg::BI_ADDR |=> oe_n_reg == !$past(addr_match);
    endproperty
    a_addr_ack: assert property (p_addr_ack) else $error("address ack wrong");

    property p_ack_hold;
        state_reg == tsc_pkg::ST_RX_ACK && !oe_n_reg && !scl_fall && !start_det
            && !stop_det && !tout_hit |=> !oe_n_reg;
    endproperty
    a_ack_hold: assert property (p_ack_hold) else $error("ack dropped early");

    property p_bad_ptr;
        byte_end && byte_reg == tsc_pkg::BI_PTR && !ptr_ok |=> oe_n_reg && $stable(ptr_reg);
    endproperty
    a_bad_ptr: assert property (p_bad_ptr) else $error("bad pointer taken");

    property p_sda_low_phase;
        $changed(oe_n_reg) && !$past(start_det) && !$past(stop_det) && !$past(tout_hit)
            |-> !$past(scl_in);
    endproperty
    a_sda_low_phase: assert property (p_sda_low_phase) else $error("data moved, clock high");

    property p_read_word;
        state_reg == tsc_pkg::ST_RX_ACK && scl_fall && !oe_n_reg && rd_reg
            && byte_reg == tsc_pkg::BI_ADDR && !start_det && !stop_det && !tout_hit
            |=> state_reg == tsc_pkg::ST_TX && shift_reg == $past(rd_word[15:8])
                && lsb_reg == $past(rd_word[7:0]);
    endproperty
    a_read_word: assert property (p_read_word) else $error("read word not loaded");

    property p_host_nak;
        state_reg == tsc_pkg::ST_TX_ACK && scl_fall && !hack_reg && !start_det
            |=> oe_n_reg [*3];
    endproperty
    a_host_nak: assert property (p_host_nak) else $error("line held after nak");

    property p_timeout;
        tout_hit |=> state_reg == tsc_pkg::ST_IDLE && oe_n_reg && tcnt_reg == '0;
    endproperty
    a_timeout: assert property (p_timeout) else $error("timeout missed");

    property p_alert;
        temp_out_of_limit |=> !alert_oe_n;
    endproperty
    a_alert: assert property (p_alert) else $error("alert not driven");

    property p_full_nak;
        byte_end && byte_reg == tsc_pkg::BI_LSB && !fifo_ready |=> oe_n_reg;
    endproperty
    a_full_nak: assert property (p_full_nak) else $error("full buffer acked");
endmodule
`default_nettype wire

// ===== tsc_pkg.sv
/*
 * Shared constants for the sensor's two-wire client port: address pattern,
 * pointer limit, byte positions, timeout and buffer sizes, state encoding.
 * Assumes a 125 MHz system clock; imported by name only, never wholesale.
 */
package tsc_pkg;
    // Clock period in nanoseconds
    localparam int CLK_NS = 8;
    // Shortest allowed bus timeout, in milliseconds
    localparam int TOUT_MS = 25;
    // Least time rounds up to whole cycles
    localparam int TOUT_CYC = (TOUT_MS * 1000000 + CLK_NS - 1) / CLK_NS;
    // Width of the timeout counter
    localparam int TOUT_W = 22;
    // Fixed upper nibble of the client address
    localparam logic [3:0] ADDR_HI = 4'h3;
    // Highest implemented register pointer
    localparam logic [7:0] PTR_MAX = 8'h09;
    // Pointer value after power-on
    localparam logic [3:0] PTR_RST = 4'h0;
    // Rising edges in one byte
    localparam logic [3:0] BIT_LAST = 4'h8;
    localparam logic [3:0] BIT_ZERO = 4'h0;
    // Position of the byte inside one access
    localparam logic [1:0] BI_ADDR = 2'h0;
    localparam logic [1:0] BI_PTR = 2'h1;
    localparam logic [1:0] BI_MSB = 2'h2;
    localparam logic [1:0] BI_LSB = 2'h3;
    // Write buffer: pointer, high byte, low byte
    localparam int FIFO_W = 20;
    localparam int FIFO_D = 32;
    // Byte-level state of the client
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_RX = 3'b001,
        ST_RX_ACK = 3'b010,
        ST_TX = 3'b011,
        ST_TX_ACK = 3'b100,
        ST_WAIT = 3'b101
    } tsc_state_type;
endpackage

// ===== tsc_fifo.sv
/*
 * Write-data buffer between the serial client and the register file.
 * Assumes one clock, synchronous active-low reset, valid/ready on both ends.
 */
`timescale 1ns/1ps
`default_nettype none
module tsc_fifo #(
    parameter int WIDTH = tsc_pkg::FIFO_W,
    parameter int DEPTH = tsc_pkg::FIFO_D
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    input wire logic out_ready,
    output logic out_valid,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH]; // Storage words
    logic [AW-1:0] wp_reg, wp_next, rp_reg, rp_next;
    logic [AW:0] cnt_reg, cnt_next; // Words held in the array
    logic ov_reg, ov_next; // Output register holds a word
    logic [WIDTH-1:0] od_reg, od_next;
    logic push, pop;

    // Pointer, count and output-stage update
    always_comb begin
        in_ready = (cnt_reg != (AW+1)'(DEPTH));
        push = in_valid && in_ready;
        pop = (cnt_reg != '0) && (!ov_reg || out_ready);
        wp_next = push ? wp_reg + AW'(1) : wp_reg;
        rp_next = pop ? rp_reg + AW'(1) : rp_reg;
        cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
        ov_next = pop ? 1'b1 : (out_ready ? 1'b0 : ov_reg);
        od_next = pop ? mem[rp_reg] : od_reg;
    end

    // Output is registered so the user side sees a flop
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            wp_reg <= '0;
            rp_reg <= '0;
            cnt_reg <= '0;
            ov_reg <= 1'b0;
            od_reg <= '0;
        end else begin
            wp_reg <= wp_next;
            rp_reg <= rp_next;
            cnt_reg <= cnt_next;
            ov_reg <= ov_next;
            od_reg <= od_next;
        end
        if (push) begin
            mem[wp_reg] <= in_data;
        end
    end

    assign out_valid = ov_reg;
    assign out_data = od_reg;
endmodule
`default_nettype wire

// ===== tsc_host.sv
/*
 * Behavioural bus host for the sensor's two-wire client port.
 * Assumes the bench resolves the data wire from both parties with a pull-up.
 */
`timescale 1ns/1ps
`default_nettype none
module tsc_host (
    input wire logic clk_sys,
    input wire logic sda_line,
    output logic scl_line,
    output logic sda_low
);
    // Half clock period in system cycles, well above the 2-cycle minimum
    localparam int HALF = 4;
    // Bus idle: both lines released
    initial begin
        scl_line = 1'b1;
        sda_low = 1'b0;
    end
    // All changes land on the falling system edge
    task automatic wait_cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    // One clock pulse; data read late in the high phase
    task automatic pulse(output logic s);
        wait_cyc(HALF);
        scl_line = 1'b1;
        wait_cyc(HALF);
        s = sda_line;
        scl_line = 1'b0;
        wait_cyc(1);
    endtask
    // Start or repeated start: data falls while clock high
    task automatic start_cond();
        sda_low = 1'b0;
        wait_cyc(HALF);
        scl_line = 1'b1;
        wait_cyc(HALF);
        sda_low = 1'b1;
        wait_cyc(HALF);
        scl_line = 1'b0;
        wait_cyc(1);
    endtask
    // Stop, then bus free time before anything else
    task automatic stop_cond();
        sda_low = 1'b1;
        wait_cyc(HALF);
        scl_line = 1'b1;
        wait_cyc(HALF);
        sda_low = 1'b0;
        wait_cyc(2 * HALF);
    endtask
    // Data set only while clock low
    task automatic send_bit(input logic b);
        logic s;
        sda_low = ~b;
        pulse(s);
    endtask
    // Byte MSB first, then ninth clock reads the acknowledge
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            send_bit(b[i]);
        end
        sda_low = 1'b0;
        pulse(s);
        ack = ~s;
    endtask
    // Byte from the client; host acks or ends the read with a nak
    task automatic recv_byte(input logic ack_it, output logic [7:0] b);
        logic s;
        sda_low = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            pulse(s);
            b[i] = s;
        end
        sda_low = ack_it;
        pulse(s);
        sda_low = 1'b0;
    endtask
endmodule
`default_nettype wire

// ===== tsc_client_tb.sv
/*
 * Self-checking bench for the client port: writes, bare reads, refusals,
 * aborts, timeout, alert and write-buffer overflow.
 * Assumes the host model in tsc_host.sv and a register file stub here.
 */
`timescale 1ns/1ps
`default_nettype none
module tsc_client_tb;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic scl_line, host_low, sda_wire, sda_out, sda_oe_n;
    logic temp_out_of_limit = 1'b0;
    logic alert_out, alert_oe_n, wr_valid;
    logic wr_ready = 1'b0;
    logic [3:0] reg_ptr;
    logic [19:0] wr_data;
    // Strap levels; the address low bits
    logic [2:0] straps = 3'b101;
    int err_total = 0;
    int compares = 0;
    int cycles = 0;
    // Top bit of each word is 0, so the client really pulls the line
    wire logic [15:0] rd_word = {4'h3, reg_ptr, 8'hA5};
    // Open-drain wire with pull-up
    assign sda_wire = ~host_low & (sda_oe_n !== 1'b0);
    always #4 clk_sys = ~clk_sys;
    tsc_client #(.TOUT_CYCLES(200)) dut_u (
        .clk_sys(clk_sys), .rst_n(rst_n), .scl_in(scl_line), .sda_in(sda_wire),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n), .addr_strap_bit0(straps[0]),
        .addr_strap_bit1(straps[1]), .addr_strap_bit2(straps[2]),
        .temp_out_of_limit(temp_out_of_limit), .alert_out(alert_out),
        .alert_oe_n(alert_oe_n), .reg_ptr(reg_ptr), .rd_word(rd_word),
        .wr_valid(wr_valid), .wr_data(wr_data), .wr_ready(wr_ready)
    );
    tsc_host host_u (
        .clk_sys(clk_sys), .sda_line(sda_wire), .scl_line(scl_line), .sda_low(host_low)
    );
    // Closing report, the single exit
    task automatic stop_test();
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // Single-bit result
    task automatic chk_bit(input string what, input logic exp, input logic got);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %s expected %b seen %b", what, exp, got);
        end
    endtask
    // Word or count result
    task automatic chk_word(input string what, input logic [19:0] exp, input logic [19:0] got);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Start, write address, pointer byte
    task automatic write_ptr(input logic [7:0] ptr, output logic a, output logic b);
        host_u.start_cond();
        host_u.send_byte({4'h3, straps, 1'b0}, a);
        host_u.send_byte(ptr, b);
    endtask
    // Pointer then one word, held back until taken
    task automatic t_write();
        logic a, b, c, d, e;
        write_ptr(8'h05, a, b);
        host_u.send_byte(8'h12, c);
        host_u.send_byte(8'h34, d);
        // A byte past the low data byte must be refused
        host_u.send_byte(8'h56, e);
        host_u.stop_cond();
        chk_bit("extra byte nak", 1'b0, e);
        chk_bit("addr ack", 1'b1, a);
        chk_bit("ptr ack", 1'b1, b);
        chk_bit("data ack", 1'b1, c & d);
        chk_bit("word valid", 1'b1, wr_valid);
        chk_word("word", 20'h51234, wr_data);
        chk_word("pointer", 20'h00005, {16'h0000, reg_ptr});
        wr_ready = 1'b1;
        @(negedge clk_sys);
        wr_ready = 1'b0;
        chk_bit("one word", 1'b0, wr_valid);
    endtask
    // Read with no pointer byte; last byte answered with nak
    task automatic t_read();
        logic a;
        logic [7:0] hi, lo;
        host_u.start_cond();
        host_u.send_byte({4'h3, straps, 1'b1}, a);
        host_u.recv_byte(1'b1, hi);
        host_u.recv_byte(1'b0, lo);
        chk_bit("line after nak", 1'b1, sda_oe_n);
        host_u.stop_cond();
        chk_bit("read ack", 1'b1, a);
        chk_word("read word", 20'h035A5, {4'h0, hi, lo});
    endtask
    // Foreign addresses and an unimplemented pointer
    task automatic t_refuse();
        logic a, b;
        host_u.start_cond();
        host_u.send_byte({4'h2, straps, 1'b0}, a);
        host_u.stop_cond();
        chk_bit("upper nibble", 1'b0, a);
        host_u.start_cond();
        host_u.send_byte({4'h3, 3'b100, 1'b0}, a);
        host_u.stop_cond();
        chk_bit("strap mismatch", 1'b0, a);
        write_ptr(8'h0A, a, b);
        host_u.stop_cond();
        chk_bit("bad ptr ack", 1'b0, b);
        chk_word("ptr kept", 20'h00005, {16'h0000, reg_ptr});
        write_ptr(8'h09, a, b);
        host_u.stop_cond();
        chk_bit("last ptr ack", 1'b1, b);
        chk_word("ptr 9", 20'h00009, {16'h0000, reg_ptr});
    endtask
    // Repeated start three bits into a byte
    task automatic t_abort();
        logic a, b;
        host_u.start_cond();
        host_u.send_bit(1'b0);
        host_u.send_bit(1'b0);
        host_u.send_bit(1'b1);
        write_ptr(8'h07, a, b);
        host_u.stop_cond();
        chk_bit("resync ack", 1'b1, a & b);
        chk_word("ptr 7", 20'h00007, {16'h0000, reg_ptr});
    endtask
    // Clock parked low while the client pulls data low
    task automatic t_timeout();
        logic a;
        host_u.start_cond();
        host_u.send_byte({4'h3, straps, 1'b1}, a);
        repeat (2) @(negedge clk_sys);
        chk_bit("first bit driven", 1'b0, sda_oe_n);
        repeat (260) @(negedge clk_sys);
        chk_bit("released on timeout", 1'b1, sda_oe_n);
        host_u.stop_cond();
    endtask
    // Alert follows the limit flag
    task automatic t_alert();
        temp_out_of_limit = 1'b1;
        repeat (2) @(negedge clk_sys);
        chk_bit("alert on", 1'b0, alert_oe_n);
        chk_bit("alert level", 1'b0, alert_out);
        temp_out_of_limit = 1'b0;
        repeat (2) @(negedge clk_sys);
        chk_bit("alert off", 1'b1, alert_oe_n);
    endtask
    // Fill the buffer with no reader until it refuses, then drain it
    task automatic t_fill();
        logic a, b, c, d;
        int n, got;
        n = 0;
        got = 0;
        for (int i = 0; i < 34; i++) begin
            write_ptr(8'h02, a, b);
            host_u.send_byte(8'h40, c);
            host_u.send_byte(i[7:0], d);
            host_u.stop_cond();
            if (d === 1'b1) n++;
            chk_bit("low ack", i < 33, d);
        end
        // 32 buffer words plus the output stage
        chk_word("accepted", 20'h00021, n[19:0]);
        chk_word("first word", 20'h24000, wr_data);
        wr_ready = 1'b1;
        repeat (80) begin
            if (wr_valid === 1'b1) got++;
            @(negedge clk_sys);
        end
        wr_ready = 1'b0;
        chk_word("drained", 20'h00021, got[19:0]);
        chk_bit("empty", 1'b0, wr_valid);
    endtask
    // Hang guard, well above the expected run
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            err_total++;
            stop_test();
        end
    end
    // Main sequence
    initial begin
        repeat (3) @(negedge clk_sys);
        rst_n = 1'b1;
        @(negedge clk_sys);
        chk_bit("idle release", 1'b1, sda_oe_n);
        chk_bit("data level", 1'b0, sda_out);
        t_write();
        t_read();
        t_refuse();
        t_abort();
        t_timeout();
        t_alert();
        t_fill();
        stop_test();
    end
endmodule
`default_nettype wire
